// ### bench/csr_host_model.sv
// Serial bus master model that reads and writes the status bank.
// Assumes the bench resolves the SDA wire and drives at falling edges.
`timescale 1ns/1ps
`default_nettype none
module csr_host_model (
    // Clock
    input  wire logic ref_clk,
    // Bus wire and master drivers
    input  wire logic sdaWire,
    output logic      sclPin,
    output logic      sdaDrive
);
    localparam int HALF = 6;
    initial begin
        sclPin = 1'b1;
        sdaDrive = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    // One SCL pulse; wire sampled just before SCL falls
    task automatic clkBit(input logic b, output logic seen);
        tick(1);
        sdaDrive = b;
        tick(HALF - 1);
        sclPin = 1'b1;
        tick(HALF);
        seen = sdaWire;
        sclPin = 1'b0;
    endtask : clkBit
    task automatic startCond;
        tick(1);
        sdaDrive = 1'b1;
        tick(HALF - 1);
        sclPin = 1'b1;
        tick(HALF);
        sdaDrive = 1'b0;
        tick(HALF);
        sclPin = 1'b0;
    endtask : startCond
    task automatic stopCond;
        tick(1);
        sdaDrive = 1'b0;
        tick(HALF - 1);
        sclPin = 1'b1;
        tick(HALF);
        sdaDrive = 1'b1;
        tick(HALF);
    endtask : stopCond
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clkBit(d[i], s);
        clkBit(1'b1, s);
        ack = ~s;
    endtask : sendByte
    task automatic readReg(input logic [6:0] a, input logic [7:0] ptr,
                           output logic [7:0] d, output logic ok);
        logic k1, k2, k3, s;
        startCond();
        sendByte({a, 1'b0}, k1);
        sendByte(ptr, k2);
        startCond();
        sendByte({a, 1'b1}, k3);
        for (int i = 7; i >= 0; i--) clkBit(1'b1, d[i]);
        clkBit(1'b1, s);
        stopCond();
        ok = k1 & k2 & k3;
    endtask : readReg
    // Two bytes in one read: master ACKs the first, NACKs the second
    task automatic readPair(input logic [6:0] a, input logic [7:0] ptr,
                            output logic [15:0] d, output logic ok);
        logic k1, k2, k3, s;
        startCond();
        sendByte({a, 1'b0}, k1);
        sendByte(ptr, k2);
        startCond();
        sendByte({a, 1'b1}, k3);
        for (int i = 15; i >= 8; i--) clkBit(1'b1, d[i]);
        clkBit(1'b0, s);
        for (int i = 7; i >= 0; i--) clkBit(1'b1, d[i]);
        clkBit(1'b1, s);
        stopCond();
        ok = k1 & k2 & k3;
    endtask : readPair
    task automatic writeReg(input logic [6:0] a, input logic [7:0] ptr,
                            input logic [7:0] v, output logic ok);
        logic k1, k2, k3;
        startCond();
        sendByte({a, 1'b0}, k1);
        sendByte(ptr, k2);
        sendByte(v, k3);
        stopCond();
        ok = k1 & k2 & k3;
    endtask : writeReg
endmodule : csr_host_model
`default_nettype wire

// ### bench/csr_status_bank_checker.sv
// Bus-side assertions for the charger status register bank.
// Assumes sdaIn carries the wired SDA level and sclIn the SCL level.
`timescale 1ns/1ps
`default_nettype none
module csr_status_bank_checker (
    // Clock and reset
    input wire logic                     ref_clk,
    input wire logic                     sys_rst,
    // Observed ports
    input wire csr_pkg::csr_status_src_t statusIn,
    input wire logic                     sclIn,
    input wire logic                     sdaIn,
    input wire logic                     sdaOut,
    input wire logic                     sdaOeN
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic       sclD;
    logic       sdaD;
    logic       drvSeen;
    logic [3:0] riseCnt;
    wire        startPin = sclIn && sclD && sdaD && !sdaIn;
    wire        stopPin  = sclIn && sclD && !sdaD && sdaIn;
    // SCL rises since the last START
    always_ff @(posedge ref_clk) begin
        sclD <= sclIn;
        sdaD <= sdaIn;
        if (sys_rst || startPin) begin
            riseCnt <= 4'h0;
            drvSeen <= 1'b0;
        end else begin
            if (sclIn && !sclD && riseCnt != 4'hF) riseCnt <= riseCnt + 4'h1;
            if (!sdaOeN) drvSeen <= 1'b1;
        end
    end
    property p_out_zero; !sdaOut; endproperty
    property p_reset_quiet;
        $fell(sys_rst) |-> (sdaOeN && !sdaOut) [*4];
    endproperty
    property p_change_timed;
        $changed(sdaOeN) |-> $past(sclIn, 4) && !$past(sclIn, 3);
    endproperty
    property p_change_low;
        $changed(sdaOeN) |-> !sclIn && !$past(sclIn) && !$past(sclIn, 2);
    endproperty
    property p_ack_hold; $fell(sdaOeN) |=> !sdaOeN [*8]; endproperty
    property p_first_ack;
        $fell(sdaOeN) && !drvSeen |-> riseCnt == 4'h8;
    endproperty
    property p_stop_idle; stopPin |=> sdaOeN [*8]; endproperty
    property p_start_idle; startPin |=> sdaOeN [*8]; endproperty
    a_out_zero: assert property (p_out_zero) else $error("sda value");
    a_reset_quiet: assert property (p_reset_quiet) else $error("rst");
    a_change_timed: assert property (p_change_timed) else $error("t");
    a_change_low: assert property (p_change_low) else $error("low");
    a_ack_hold: assert property (p_ack_hold) else $error("hold");
    a_first_ack: assert property (p_first_ack) else $error("count");
    a_stop_idle: assert property (p_stop_idle) else $error("stop");
    a_start_idle: assert property (p_start_idle) else $error("sta");
    c_ack: cover property ($fell(sdaOeN) && riseCnt == 4'h8);
    c_start: cover property (startPin);
    c_stop: cover property (stopPin);
endmodule : csr_status_bank_checker
bind csr_status_bank csr_status_bank_checker i_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .statusIn(statusIn),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN)
);
`default_nettype wire

// ### bench/csr_status_bank_tb.sv
// Self-checking bench for the charger status register bank.
// Assumes csr_params.svh on the include path and a pull-up on SDA.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"
module csr_status_bank_tb;
    localparam logic [6:0] ADDR = `CSR_DEV_ADDR;
    logic                     ref_clk = 1'b0;
    logic                     sys_rst = 1'b1;
    csr_pkg::csr_status_src_t src = '0;
    logic                     sclPin, sdaDrive, sdaOeN, sdaOut, ok;
    wire                      sdaWire = sdaDrive && (sdaOeN !== 1'b0);
    logic [7:0]               rd, e;
    logic [8:0]               v;
    logic [15:0]              pairRd;
    int                       errCount = 0, checkCount = 0, cycles = 0;
    always #5 ref_clk = ~ref_clk;
    csr_status_bank #(.DEV_ADDR(ADDR)) i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .statusIn(src),
        .sclIn(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN)
    );
    csr_host_model i_host (
        .ref_clk(ref_clk), .sdaWire(sdaWire),
        .sclPin(sclPin), .sdaDrive(sdaDrive)
    );
    function automatic logic [3:0] srcExp(input logic [3:0] c);
        return (c inside {4'h9, 4'hA, [4'hC:4'hF]}) ? 4'h0 : c;
    endfunction : srcExp
    task automatic check(input string nm, input logic [7:0] seen, exp);
        checkCount++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic rdChk(input logic [7:0] ptr, exp);
        i_host.readReg(ADDR, ptr, rd, ok);
        check("ack", {7'h00, ok}, 8'h01);
        check($sformatf("reg %h", ptr), rd, exp);
    endtask : rdChk
    task automatic endOfTest;
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : endOfTest
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errCount++;
            endOfTest();
        end
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        rdChk(`CSR_OFS_SRC_CHG, `CSR_RST_STATUS);
        rdChk(`CSR_OFS_OPT_THM, `CSR_RST_STATUS);
        rdChk(`CSR_OFS_FET_TMR, `CSR_RST_STATUS);
        for (int k = 0; k < 16; k++) begin
            @(negedge ref_clk);
            src.sourceType = k[3:0];
            src.chargePhase = k[2:0];
            src.portDetectDone = k[0];
            e = {(k[2:0] == 3'h5) ? 3'h0 : k[2:0], srcExp(k[3:0]), k[0]};
            rdChk(`CSR_OFS_SRC_CHG, e);
        end
        // Hot or cold battery in OTG mode hides the source
        for (int j = 0; j < 3; j++) begin
            @(negedge ref_clk);
            src.sourceType = 4'h3;
            src.otgMode = 1'b1;
            src.batteryHot = (j == 1);
            src.batteryCold = (j == 2);
            rdChk(`CSR_OFS_SRC_CHG, {3'h7, (j == 0) ? 4'h3 : 4'h0, 1'b1});
        end
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            src.optimizerState = i[1:0];
            src.thermalReg = i[2];
            src.datalineActive = i[0];
            src.cellPresent = i[1];
            e = {(i[1:0] == 2'h3) ? 2'h0 : i[1:0], 3'h0, i[2], i[0], i[1]};
            rdChk(`CSR_OFS_OPT_THM, e);
        end
        i_host.writeReg(ADDR, `CSR_OFS_OPT_THM, 8'hFF, ok);
        check("write ack", {7'h00, ok}, 8'h01);
        rdChk(`CSR_OFS_OPT_THM, e);
        for (int i = 0; i < 12; i++) begin
            v = (i < 9) ? (9'h001 << i) : (i == 9) ? 9'h1FF
                : (i == 10) ? 9'h060 : 9'h018;
            @(negedge ref_clk);
            {src.fet2Fitted, src.fet1Fitted, src.adcDone,
             src.adcOneShotMode, src.minSysReg, src.forwardMode,
             src.fastTimeout, src.trickleTimeout, src.preTimeout} = v;
            e = {v[8], v[7], v[6] & v[5], v[4] & v[3], v[2:0], 1'b0};
            rdChk(`CSR_OFS_FET_TMR, e);
        end
        // Pointer advances from 1Dh to 1Eh within one read
        i_host.readPair(ADDR, `CSR_OFS_OPT_THM, pairRd, ok);
        check("pair ack", {7'h00, ok}, 8'h01);
        check("pair first", pairRd[15:8], 8'h07);
        check("pair second", pairRd[7:0], e);
        rdChk(8'h40, `CSR_RST_STATUS);
        i_host.readReg(ADDR ^ 7'h01, `CSR_OFS_FET_TMR, rd, ok);
        check("foreign address", {7'h00, ok}, 8'h00);
        endOfTest();
    end
endmodule : csr_status_bank_tb
`default_nettype wire

// ### rtl/csr_params.svh
// Constants of the charger status register bank: offsets, bit positions,
// reset values and serial-bus counts.
// Assumes inclusion by bare name from the rtl/ directory.
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// Register offsets on the serial control bus
`define CSR_OFS_SRC_CHG      8'h1C
`define CSR_OFS_OPT_THM      8'h1D
`define CSR_OFS_FET_TMR      8'h1E

// Reset value of every status register and of unmapped reads
`define CSR_RST_STATUS       8'h00

// Default 7-bit bus address; the value is arbitrary
`define CSR_DEV_ADDR         7'h2A

// Input source and charge register fields
`define CSR_POS_CHG_PHASE    5
`define CSR_POS_SRC_TYPE     1
`define CSR_POS_DETECT_DONE  0

// Optimizer, thermal and detection register fields
`define CSR_POS_OPT_STATE    6
`define CSR_POS_THERM_REG    2
`define CSR_POS_DATALINE     1
`define CSR_POS_CELL         0

// FET, ADC and timer register fields
`define CSR_POS_FET2         7
`define CSR_POS_FET1         6
`define CSR_POS_ADC_DONE     5
`define CSR_POS_MIN_SYS      4
`define CSR_POS_FAST_TMO     3
`define CSR_POS_TRICKLE_TMO  2
`define CSR_POS_PRE_TMO      1

// Synchroniser depth and bits in one bus byte
`define CSR_SYNC_STAGES      2
`define CSR_BYTE_BITS        4'h8

`endif

// ### rtl/csr_pkg.sv
// Types of the charger status register bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package csr_pkg;

    // Detected input source type codes
    typedef enum logic [3:0] {
        CSR_SRC_NONE     = 4'h0,
        CSR_SRC_SDP      = 4'h1,
        CSR_SRC_CDP      = 4'h2,
        CSR_SRC_DCP      = 4'h3,
        CSR_SRC_HV_DEDICATED = 4'h4,
        CSR_SRC_UNKNOWN  = 4'h5,
        CSR_SRC_NONSTD   = 4'h6,
        CSR_SRC_OTG      = 4'h7,
        CSR_SRC_UNQUAL   = 4'h8,
        CSR_SRC_DIRECT   = 4'hB
    } csr_src_type_t;

    // Charge phase codes that matter here
    typedef enum logic [2:0] {
        CSR_PHASE_IDLE     = 3'h0,
        CSR_PHASE_TAPER    = 3'h4,
        CSR_PHASE_RSVD     = 3'h5,
        CSR_PHASE_TOPOFF   = 3'h6,
        CSR_PHASE_TERMDONE = 3'h7
    } csr_phase_t;

    // Input current optimizer states
    typedef enum logic [1:0] {
        CSR_OPT_DISABLED = 2'h0,
        CSR_OPT_RUNNING  = 2'h1,
        CSR_OPT_FOUND    = 2'h2,
        CSR_OPT_RSVD     = 2'h3
    } csr_opt_state_t;

    // Source conditions from converter, detection, ADC and timer logic
    typedef struct packed {
        logic [2:0] chargePhase;
        logic [3:0] sourceType;
        logic       portDetectDone;
        logic [1:0] optimizerState;
        logic       thermalReg;
        logic       datalineActive;
        logic       cellPresent;
        logic       fet2Fitted;
        logic       fet1Fitted;
        logic       adcDone;
        logic       adcOneShotMode;
        logic       minSysReg;
        logic       forwardMode;
        logic       fastTimeout;
        logic       trickleTimeout;
        logic       preTimeout;
        logic       otgMode;
        logic       batteryHot;
        logic       batteryCold;
    } csr_status_src_t;

    // Serial bus pins as seen after synchronisation
    typedef struct packed {
        logic scl;
        logic sda;
    } csr_bus_pins_t;

    // Serial slave states
    typedef enum logic [8:0] {
        CSR_ST_IDLE     = 9'h001,
        CSR_ST_ADDR     = 9'h002,
        CSR_ST_ADDR_ACK = 9'h004,
        CSR_ST_WBYTE    = 9'h008,
        CSR_ST_WACK     = 9'h010,
        CSR_ST_RDATA    = 9'h020,
        CSR_ST_RACK     = 9'h040,
        CSR_ST_WAIT     = 9'h080,
        CSR_ST_SPARE    = 9'h100
    } csr_state_t;

endpackage : csr_pkg
`default_nettype wire

// ### rtl/csr_status_bank.sv
// Read-only charger status register bank behind a serial control bus
// slave (7-bit address, register pointer, auto-increment).
// Assumes source conditions are levels from other domains and that the
// bus master never stretches beyond the standard bus protocol.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"

module csr_status_bank #(
    parameter logic [6:0] DEV_ADDR = `CSR_DEV_ADDR
) (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    // Source conditions
    input  wire csr_pkg::csr_status_src_t statusIn,
    // Serial bus pins
    input  wire logic                     sclIn,
    input  wire logic                     sdaIn,
    output logic                          sdaOut,
    output logic                          sdaOeN
);

    generate
        if (DEV_ADDR == 7'h00) begin : gBadAddr
            $error("DEV_ADDR must not be the general call address");
        end
    endgenerate

    // Synchronised inputs
    csr_pkg::csr_status_src_t statusS;
    csr_pkg::csr_bus_pins_t   pinsS;

    csr_sync #(
        .WIDTH ($bits(csr_pkg::csr_status_src_t))
    ) uStatusSync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn (statusIn),
        .syncOut (statusS)
    );

    csr_sync #(
        .WIDTH ($bits(csr_pkg::csr_bus_pins_t))
    ) uPinSync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn ({sclIn, sdaIn}),
        .syncOut (pinsS)
    );

    // Status field filtering
    logic       srcCodeValid;
    logic       otgBattBlock;
    logic [3:0] srcCode;
    logic [2:0] phaseCode;
    logic [1:0] optCode;

    assign srcCodeValid = (statusS.sourceType <= 4'(csr_pkg::CSR_SRC_UNQUAL))
                        || (statusS.sourceType == 4'(csr_pkg::CSR_SRC_DIRECT));
    assign otgBattBlock = statusS.otgMode
                        & (statusS.batteryHot | statusS.batteryCold);
    assign srcCode      = (srcCodeValid && !otgBattBlock)
                        ? statusS.sourceType
                        : 4'(csr_pkg::CSR_SRC_NONE);
    assign phaseCode    = (statusS.chargePhase == 3'(csr_pkg::CSR_PHASE_RSVD))
                        ? 3'(csr_pkg::CSR_PHASE_IDLE)
                        : statusS.chargePhase;
    assign optCode      = (statusS.optimizerState
                           == 2'(csr_pkg::CSR_OPT_RSVD))
                        ? 2'(csr_pkg::CSR_OPT_DISABLED)
                        : statusS.optimizerState;

    // Register images; reserved bits stay zero
    logic [7:0] srcChgNext;
    logic [7:0] optThmNext;
    logic [7:0] fetTmrNext;

    always_comb begin
        srcChgNext = `CSR_RST_STATUS;
        srcChgNext[`CSR_POS_CHG_PHASE +: 3] = phaseCode;
        srcChgNext[`CSR_POS_SRC_TYPE +: 4]  = srcCode;
        srcChgNext[`CSR_POS_DETECT_DONE]    = statusS.portDetectDone;
    end

    always_comb begin
        optThmNext = `CSR_RST_STATUS;
        optThmNext[`CSR_POS_OPT_STATE +: 2] = optCode;
        optThmNext[`CSR_POS_THERM_REG]      = statusS.thermalReg;
        optThmNext[`CSR_POS_DATALINE]       = statusS.datalineActive;
        optThmNext[`CSR_POS_CELL]           = statusS.cellPresent;
    end

    always_comb begin
        fetTmrNext = `CSR_RST_STATUS;
        fetTmrNext[`CSR_POS_FET2]        = statusS.fet2Fitted;
        fetTmrNext[`CSR_POS_FET1]        = statusS.fet1Fitted;
        fetTmrNext[`CSR_POS_ADC_DONE]    = statusS.adcDone
                                         & statusS.adcOneShotMode;
        fetTmrNext[`CSR_POS_MIN_SYS]     = statusS.minSysReg
                                         & statusS.forwardMode;
        fetTmrNext[`CSR_POS_FAST_TMO]    = statusS.fastTimeout;
        fetTmrNext[`CSR_POS_TRICKLE_TMO] = statusS.trickleTimeout;
        fetTmrNext[`CSR_POS_PRE_TMO]     = statusS.preTimeout;
    end

    // Status registers follow their sources every cycle
    logic [7:0] srcChgReg;
    logic [7:0] optThmReg;
    logic [7:0] fetTmrReg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            srcChgReg <= `CSR_RST_STATUS;
            optThmReg <= `CSR_RST_STATUS;
            fetTmrReg <= `CSR_RST_STATUS;
        end else begin
            srcChgReg <= srcChgNext;
            optThmReg <= optThmNext;
            fetTmrReg <= fetTmrNext;
        end
    end

    // Bus edge and condition detection
    logic sclDReg;
    logic sdaDReg;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sclDReg <= 1'b1;
            sdaDReg <= 1'b1;
        end else begin
            sclDReg <= pinsS.scl;
            sdaDReg <= pinsS.sda;
        end
    end

    assign sclRise   = pinsS.scl & ~sclDReg;
    assign sclFall   = ~pinsS.scl & sclDReg;
    assign startCond = pinsS.scl & sclDReg & sdaDReg & ~pinsS.sda;
    assign stopCond  = pinsS.scl & sclDReg & ~sdaDReg & pinsS.sda;

    // Slave state
    csr_pkg::csr_state_t stateReg;
    csr_pkg::csr_state_t stateNext;
    logic [3:0]          bitCntReg;
    logic [3:0]          bitCntNext;
    logic [7:0]          shiftReg;
    logic [7:0]          shiftNext;
    logic [7:0]          txReg;
    logic [7:0]          txNext;
    logic [7:0]          ptrReg;
    logic [7:0]          ptrNext;
    logic                rwReg;
    logic                rwNext;
    logic                havePtrReg;
    logic                havePtrNext;
    logic                nackReg;
    logic                nackNext;
    logic                oeNReg;
    logic                oeNNext;

    // Read decode; unmapped offsets read zero
    logic       hitSrcChg;
    logic       hitOptThm;
    logic       hitFetTmr;
    logic [7:0] readByte;
    logic       addrMatch;
    logic       byteDone;

    assign hitSrcChg = (ptrReg == `CSR_OFS_SRC_CHG);
    assign hitOptThm = (ptrReg == `CSR_OFS_OPT_THM);
    assign hitFetTmr = (ptrReg == `CSR_OFS_FET_TMR);
    assign readByte  = hitSrcChg ? srcChgReg
                     : hitOptThm ? optThmReg
                     : hitFetTmr ? fetTmrReg
                     : `CSR_RST_STATUS;
    assign addrMatch = (shiftReg[7:1] == DEV_ADDR);
    assign byteDone  = (bitCntReg == `CSR_BYTE_BITS);

    always_comb begin
        stateNext   = stateReg;
        bitCntNext  = bitCntReg;
        shiftNext   = shiftReg;
        txNext      = txReg;
        ptrNext     = ptrReg;
        rwNext      = rwReg;
        havePtrNext = havePtrReg;
        nackNext    = nackReg;
        oeNNext     = oeNReg;
        if (startCond) begin
            stateNext  = csr_pkg::CSR_ST_ADDR;
            bitCntNext = 4'h0;
            oeNNext    = 1'b1;
        end else if (stopCond) begin
            stateNext = csr_pkg::CSR_ST_IDLE;
            oeNNext   = 1'b1;
        end else begin
            case (stateReg)
                csr_pkg::CSR_ST_ADDR, csr_pkg::CSR_ST_WBYTE: begin
                    if (sclRise) begin
                        shiftNext  = {shiftReg[6:0], pinsS.sda};
                        bitCntNext = 4'(bitCntReg + 4'h1);
                    end else if (sclFall && byteDone) begin
                        if (stateReg == csr_pkg::CSR_ST_WBYTE) begin
                            oeNNext   = 1'b0;
                            stateNext = csr_pkg::CSR_ST_WACK;
                            // Data bytes are acknowledged and dropped
                            if (!havePtrReg) begin
                                ptrNext     = shiftReg;
                                havePtrNext = 1'b1;
                            end else begin
                                ptrNext = 8'(ptrReg + 8'h01);
                            end
                        end else if (addrMatch) begin
                            oeNNext   = 1'b0;
                            rwNext    = shiftReg[0];
                            stateNext = csr_pkg::CSR_ST_ADDR_ACK;
                        end else begin
                            stateNext = csr_pkg::CSR_ST_WAIT;
                        end
                    end
                end
                csr_pkg::CSR_ST_ADDR_ACK: begin
                    if (sclFall) begin
                        bitCntNext = 4'h0;
                        if (rwReg) begin
                            txNext    = readByte;
                            oeNNext   = readByte[7];
                            ptrNext   = 8'(ptrReg + 8'h01);
                            stateNext = csr_pkg::CSR_ST_RDATA;
                        end else begin
                            oeNNext     = 1'b1;
                            havePtrNext = 1'b0;
                            stateNext   = csr_pkg::CSR_ST_WBYTE;
                        end
                    end
                end
                csr_pkg::CSR_ST_WACK: begin
                    if (sclFall) begin
                        oeNNext    = 1'b1;
                        bitCntNext = 4'h0;
                        stateNext  = csr_pkg::CSR_ST_WBYTE;
                    end
                end
                csr_pkg::CSR_ST_RDATA: begin
                    if (sclRise) begin
                        bitCntNext = 4'(bitCntReg + 4'h1);
                    end else if (sclFall) begin
                        if (byteDone) begin
                            oeNNext   = 1'b1;
                            stateNext = csr_pkg::CSR_ST_RACK;
                        end else begin
                            txNext  = {txReg[6:0], 1'b0};
                            oeNNext = txReg[6];
                        end
                    end
                end
                csr_pkg::CSR_ST_RACK: begin
                    if (sclRise) begin
                        nackNext = pinsS.sda;
                    end else if (sclFall) begin
                        bitCntNext = 4'h0;
                        if (nackReg) begin
                            stateNext = csr_pkg::CSR_ST_WAIT;
                        end else begin
                            txNext    = readByte;
                            oeNNext   = readByte[7];
                            ptrNext   = 8'(ptrReg + 8'h01);
                            stateNext = csr_pkg::CSR_ST_RDATA;
                        end
                    end
                end
                csr_pkg::CSR_ST_IDLE, csr_pkg::CSR_ST_WAIT: begin
                    oeNNext = 1'b1;
                end
                default: begin
                    oeNNext   = 1'b1;
                    stateNext = csr_pkg::CSR_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stateReg   <= csr_pkg::CSR_ST_IDLE;
            bitCntReg  <= 4'h0;
            shiftReg   <= 8'h00;
            txReg      <= 8'h00;
            ptrReg     <= 8'h00;
            rwReg      <= 1'b0;
            havePtrReg <= 1'b0;
            nackReg    <= 1'b0;
            oeNReg     <= 1'b1;
        end else begin
            stateReg   <= stateNext;
            bitCntReg  <= bitCntNext;
            shiftReg   <= shiftNext;
            txReg      <= txNext;
            ptrReg     <= ptrNext;
            rwReg      <= rwNext;
            havePtrReg <= havePtrNext;
            nackReg    <= nackNext;
            oeNReg     <= oeNNext;
        end
    end

    // Open-drain pin: only ever pulled low
    assign sdaOut = 1'b0;
    assign sdaOeN = oeNReg;

endmodule : csr_status_bank
`default_nettype wire

// ### rtl/csr_sync.sv
// Multi-bit level synchroniser, two flip-flops per bit.
// Assumes each bit is an independent level from outside ref_clk's domain.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"

module csr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    generate
        if (WIDTH < 1) begin : gBadWidth
            $error("csr_sync needs WIDTH of at least one");
        end
    endgenerate

    logic [WIDTH-1:0] stage1Reg;
    logic [WIDTH-1:0] stage2Reg;

    // First stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stage1Reg <= '0;
            stage2Reg <= '0;
        end else begin
            stage1Reg <= asyncIn;
            stage2Reg <= stage1Reg;
        end
    end

    assign syncOut = stage2Reg;

endmodule : csr_sync
`default_nettype wire
